//--- verilog/ust_pkg.sv
// constants and types of the unipolar stepper translator
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`default_nettype none

package ust_pkg;

  // drive format, one-hot
  typedef enum logic [3:0] {
    FMT_WAVE    = 4'b0001,
    FMT_TWO     = 4'b0010,
    FMT_HALF    = 4'b0100,
    FMT_INHIBIT = 4'b1000
  } ust_fmt_e;

  // thermal guard state, one-hot
  typedef enum logic [1:0] {
    TH_RUN  = 2'b01,
    TH_SHUT = 2'b10
  } ust_therm_e;

  // phase pattern tables, bit 0 = A .. bit 3 = D, position 0 in lowest nibble
  localparam logic [15:0] WAVE_TBL    = 16'h8421;
  localparam logic [15:0] TWO_TBL     = 16'hC639;
  localparam logic [31:0] HALF_TBL    = 32'h98C46231;
  localparam logic [2:0]  POS_FIRST   = 3'h0;
  localparam logic [3:0]  PHASE_RESET = 4'h1;
  localparam logic [3:0]  PHASE_OFF   = 4'h0;

  // register byte offsets
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_IRQ_STAT = 4'h8;
  localparam logic [3:0]  REG_IRQ_MASK = 4'hC;

  // field positions
  localparam int CTRL_SOFT_BLANK = 0;
  localparam int ST_POS_LSB      = 0;
  localparam int ST_FMT_LSB      = 3;
  localparam int ST_DIR          = 7;
  localparam int ST_THERM        = 8;
  localparam int ST_PHASE_LSB    = 12;
  localparam int IRQ_W           = 4;
  localparam int IRQ_STEP        = 0;
  localparam int IRQ_INHIBIT     = 1;
  localparam int IRQ_TRIP        = 2;
  localparam int IRQ_RECOVER     = 3;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int         PIN_W      = 7;

endpackage

`default_nettype wire

//--- verilog/ust_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none

module ust_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

`default_nettype wire

//--- verilog/ust_phase_dec.sv
// phase pattern lookup for each drive format and position
`timescale 1ns/100ps
`default_nettype none

module ust_phase_dec (
  // selection
  input  wire ust_pkg::ust_fmt_e fmt_i,
  input  wire logic [2:0]        pos_i,
  // pattern, bit 0 = A
  output logic      [3:0]        pattern_o
);
  import ust_pkg::*;

  // table lookup; inhibit shows the half-step table pattern of pos in every case
  always_comb begin
    case (fmt_i)
      FMT_WAVE:    pattern_o = WAVE_TBL[{pos_i[1:0], 2'b00} +: 4];
      FMT_TWO:     pattern_o = TWO_TBL[{pos_i[1:0], 2'b00} +: 4];
      FMT_HALF:    pattern_o = HALF_TBL[{pos_i, 2'b00} +: 4];
      FMT_INHIBIT: pattern_o = HALF_TBL[{pos_i, 2'b00} +: 4];
      default:     pattern_o = PHASE_OFF;
    endcase
  end

endmodule

`default_nettype wire

//--- verilog/ust_top.sv
// stepper translator top: pin sequencer, thermal guard, AHB-Lite registers
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ust_top (
  // clock and reset
  input  wire logic                     CLK_I,
  input  wire logic                     RESETN_I,
  // AHB-Lite slave
  input  wire logic                     HSEL_I,
  input  wire logic [31:0]              HADDR_I,
  input  wire logic [1:0]               HTRANS_I,
  input  wire logic                     HWRITE_I,
  input  wire logic [2:0]               HSIZE_I,
  input  wire logic [31:0]              HWDATA_I,
  input  wire logic                     HREADY_I,
  output logic      [31:0]              HRDATA_O,
  output logic                          HREADYOUT_O,
  output logic                          HRESP_O,
  // step controller pins
  input  wire logic                     STEP_I,
  input  wire logic                     HALF_STEP_I,
  input  wire logic                     ONE_PHASE_I,
  input  wire logic                     DIR_I,
  input  wire logic                     BLANK_I,
  // thermal sensor comparators
  input  wire logic                     OT_HOT_I,
  input  wire logic                     OT_COOL_I,
  // motor phases and interrupt
  output logic      [3:0]               PHASE_O,
  output logic                          IRQ_O
);
  import ust_pkg::*;

  //----------------------------------------------------------------------------
  // pin synchronisation
  //----------------------------------------------------------------------------
  logic [PIN_W-1:0] pin_s;
  logic             step_s;
  logic             half_s;
  logic             one_s;
  logic             dir_s;
  logic             blank_s;
  logic             hot_s;
  logic             cool_s;
  logic             step_q;
  logic             step_fall;

  ust_sync #(.W(PIN_W)) u_sync (
    .clk_i  (CLK_I),
    .rstn_i (RESETN_I),
    .d_i    ({OT_COOL_I, OT_HOT_I, BLANK_I, DIR_I, ONE_PHASE_I, HALF_STEP_I, STEP_I}),
    .q_o    (pin_s)
  );

  // split synchronised levels
  assign {cool_s, hot_s, blank_s, dir_s, one_s, half_s, step_s} = pin_s;

  // previous step level for edge detection
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      step_q <= 1'b0;
    end else begin
      step_q <= step_s;
    end
  end

  assign step_fall = step_q & ~step_s;

  //----------------------------------------------------------------------------
  // format decode and sequencer
  //----------------------------------------------------------------------------
  ust_fmt_e   fmt;
  logic [2:0] pos;
  logic [2:0] next_pos;
  logic [3:0] pattern;
  logic       step_take;

  // select pins to format
  always_comb begin
    case ({half_s, one_s})
      2'b01:   fmt = FMT_WAVE;
      2'b00:   fmt = FMT_TWO;
      2'b10:   fmt = FMT_HALF;
      default: fmt = FMT_INHIBIT;
    endcase
  end

  assign step_take = step_fall & (fmt != FMT_INHIBIT);

  // next position, wrapping per format
  always_comb begin
    next_pos = pos;
    if (step_take) begin
      if (fmt == FMT_HALF) begin
        next_pos = dir_s ? pos - 3'h1 : pos + 3'h1;
      end else begin
        next_pos = {1'b0, (dir_s ? pos[1:0] - 2'h1 : pos[1:0] + 2'h1)};
      end
    end
  end

  // position register, first position after reset
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      pos <= POS_FIRST;
    end else begin
      pos <= next_pos;
    end
  end

  ust_phase_dec u_dec (
    .fmt_i     (fmt),
    .pos_i     (pos),
    .pattern_o (pattern)
  );

  //----------------------------------------------------------------------------
  // thermal guard with hysteresis
  //----------------------------------------------------------------------------
  ust_therm_e th_state;
  logic       ev_trip;
  logic       ev_recover;

  assign ev_trip    = (th_state == TH_RUN) & hot_s;
  assign ev_recover = (th_state == TH_SHUT) & cool_s & ~hot_s;

  // trip at the hot threshold, release only once cooled
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      th_state <= TH_RUN;
    end else begin
      case (th_state)
        TH_RUN:  th_state <= ev_trip ? TH_SHUT : TH_RUN;
        TH_SHUT: th_state <= ev_recover ? TH_RUN : TH_SHUT;
        default: th_state <= TH_RUN;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // phase outputs
  //----------------------------------------------------------------------------
  logic soft_blank;
  logic phase_off;

  assign phase_off = blank_s | soft_blank | (th_state == TH_SHUT);

  // blanking gates the drive only, position is untouched
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      PHASE_O <= PHASE_RESET;
    end else if (phase_off) begin
      PHASE_O <= PHASE_OFF;
    end else begin
      PHASE_O <= pattern;
    end
  end

  //----------------------------------------------------------------------------
  // AHB-Lite slave
  //----------------------------------------------------------------------------
  logic              ahb_go;
  logic              rd_pend;
  logic              wr_pend;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       rdata;
  logic              rd_clear;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  next_irq_stat;
  logic [IRQ_W-1:0]  irq_ev;

  // only whole-word transfers are acted upon
  assign ahb_go = HSEL_I & HTRANS_I[1] & HREADY_I & (HSIZE_I == HSIZE_WORD);

  // address phase capture; reads add one wait state
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rd_pend     <= 1'b0;
      wr_pend     <= 1'b0;
      addr        <= '0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      rd_pend     <= ahb_go & ~HWRITE_I;
      wr_pend     <= ahb_go & HWRITE_I;
      HREADYOUT_O <= ~(ahb_go & ~HWRITE_I);
      HRESP_O     <= 1'b0; // always OKAY
      if (ahb_go) begin
        addr <= HADDR_I[ADDR_W-1:0];
      end
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata = '0;
    case (addr)
      REG_CTRL:     rdata[CTRL_SOFT_BLANK] = soft_blank;
      REG_STATUS: begin
        rdata[ST_POS_LSB +: 3]   = pos;
        rdata[ST_FMT_LSB +: 4]   = fmt;
        rdata[ST_DIR]            = dir_s;
        rdata[ST_THERM]          = (th_state == TH_SHUT);
        rdata[ST_PHASE_LSB +: 4] = PHASE_O;
      end
      REG_IRQ_STAT: rdata[IRQ_W-1:0] = irq_stat;
      REG_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask;
      default:      rdata = '0;
    endcase
  end

  // read data in the wait cycle
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      HRDATA_O <= '0;
    end else if (rd_pend) begin
      HRDATA_O <= rdata;
    end
  end

  // software registers written in the data phase
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      soft_blank <= 1'b0;
      irq_mask   <= '0;
    end else if (wr_pend) begin
      if (addr == REG_CTRL) begin
        soft_blank <= HWDATA_I[CTRL_SOFT_BLANK];
      end
      if (addr == REG_IRQ_MASK) begin
        irq_mask <= HWDATA_I[IRQ_W-1:0];
      end
    end
  end

  //----------------------------------------------------------------------------
  // interrupts: sticky status cleared by read, new events win
  //----------------------------------------------------------------------------
  assign rd_clear = rd_pend & (addr == REG_IRQ_STAT);

  always_comb begin
    irq_ev              = '0;
    irq_ev[IRQ_STEP]    = step_take;
    irq_ev[IRQ_INHIBIT] = step_fall & (fmt == FMT_INHIBIT);
    irq_ev[IRQ_TRIP]    = ev_trip;
    irq_ev[IRQ_RECOVER] = ev_recover;
    next_irq_stat       = (rd_clear ? '0 : irq_stat) | irq_ev;
  end

  // status and level interrupt
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      irq_stat <= '0;
      IRQ_O    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      IRQ_O    <= |(next_irq_stat & irq_mask);
    end
  end

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  chk_reset_first: assert property (disable iff (1'b0)
    !RESETN_I |=> pos == POS_FIRST && PHASE_O == PHASE_RESET)
    else $error("reset did not load the first position");

  chk_step_moves: assert property (
    step_fall && fmt != FMT_INHIBIT |=> pos != $past(pos))
    else $error("falling step edge did not move the sequencer");

  chk_no_rise_move: assert property (
    !step_fall |=> $stable(pos))
    else $error("sequencer moved without a falling step edge");

  chk_inhibit_hold: assert property (
    step_fall && half_s && one_s |=> $stable(pos))
    else $error("step advanced while inhibited");

  chk_half_wrap: assert property (
    step_fall && fmt == FMT_HALF && !dir_s && pos == 3'h7 |=> pos == POS_FIRST)
    else $error("half-step forward did not wrap to the first position");

  chk_reverse_wrap: assert property (
    step_fall && fmt == FMT_WAVE && dir_s && pos == POS_FIRST |=> pos == 3'h3)
    else $error("reverse wave step did not wrap to the last position");

  chk_fwd_order: assert property (
    step_fall && fmt == FMT_TWO && !dir_s && pos == 3'h1 |=> pos == 3'h2)
    else $error("forward two-phase step went the wrong way");

  chk_four_wrap: assert property (
    step_fall && fmt == FMT_TWO && pos[2] |=> !pos[2])
    else $error("four-step format left the position above four");

  chk_wave_single: assert property (
    fmt == FMT_WAVE |-> $onehot(pattern))
    else $error("wave drive did not energise exactly one phase");

  chk_two_pair: assert property (
    fmt == FMT_TWO |-> $countones(pattern) == 2 && pattern != 4'h5 && pattern != 4'hA)
    else $error("two-phase drive not on two adjacent phases");

  chk_half_alt: assert property (
    fmt == FMT_HALF |-> $countones(pattern) == (pos[0] ? 2 : 1))
    else $error("half-step did not alternate one and two phases");

  chk_blank_off: assert property (
    blank_s |=> PHASE_O == PHASE_OFF)
    else $error("phases driven while blanked");

  chk_follow: assert property (
    !phase_off |=> PHASE_O == $past(pattern))
    else $error("phases do not follow the sequencer pattern");

  chk_therm_hold: assert property (
    th_state == TH_SHUT && !cool_s |=> th_state == TH_SHUT ##0 PHASE_O == PHASE_OFF)
    else $error("thermal shutdown released before cooling");

  chk_fmt_decode: assert property (
    !half_s && !one_s |-> fmt == FMT_TWO)
    else $error("both selects low did not give two-phase drive");

  chk_read_wait: assert property (
    ahb_go && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("read did not insert exactly one wait state");

  chk_irq_level: assert property (
    IRQ_O == |(irq_stat & irq_mask))
    else $error("interrupt level does not follow the unmasked status");

  cov_half_step:  cover property (step_fall && fmt == FMT_HALF ##1 pos == 3'h1);
  cov_reverse:    cover property (step_fall && dir_s && fmt == FMT_WAVE);
  cov_therm_trip: cover property (ev_trip ##[1:50] ev_recover);
  cov_irq_read:   cover property (IRQ_O ##1 rd_clear);

endmodule

`default_nettype wire

//--- testbench/ust_ctl_model.sv
// step controller model that drives the translator step and select pins
`timescale 1ns/100ps
`default_nettype none

module ust_ctl_model (
  // clock
  input  wire logic clk_i,
  // controller pins
  output var logic  step_o,
  output var logic  half_o,
  output var logic  one_o,
  output var logic  dir_o
);
  // pins start low: step idle, two-phase, forward
  initial begin
    step_o = 1'b0;
    half_o = 1'b0;
    one_o  = 1'b0;
    dir_o  = 1'b0;
  end

  // selects move only while step rests low, then settle before any pulse
  task automatic set_mode(input logic h, input logic o, input logic d);
    @(posedge clk_i);
    step_o <= 1'b0;
    half_o <= h;
    one_o  <= o;
    dir_o  <= d;
    repeat (6) @(posedge clk_i);
  endtask

  // step pin to a level, held for a prompt or a slow number of cycles
  task automatic drive(input logic lvl, input int hold);
    @(posedge clk_i);
    step_o <= lvl;
    repeat (hold) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench of the stepper translator
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import ust_pkg::*;
  //----------------------------------------
  // signals and instances
  //----------------------------------------
  logic        clk = 1'b0;
  logic        rstn, hsel, hwrite, hready, hresp, blank, hot, cool, irq;
  logic        step, half, one, dir;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  phase, held;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          n_fail, total_checks, seed, pos, fmt, n;

  // translator; the slave's own ready closes the bus loop
  ust_top dut_u (
    .CLK_I(clk), .RESETN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .STEP_I(step),
    .HALF_STEP_I(half), .ONE_PHASE_I(one), .DIR_I(dir), .BLANK_I(blank),
    .OT_HOT_I(hot), .OT_COOL_I(cool), .PHASE_O(phase), .IRQ_O(irq)
  );

  // step controller on the pin side
  ust_ctl_model ctl_u (
    .clk_i(clk), .step_o(step), .half_o(half), .one_o(one), .dir_o(dir)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  //----------------------------------------
  // tasks and expectations
  //----------------------------------------
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  // compare a register word
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // compare the phase outputs
  task automatic chk_ph(input logic [3:0] exp);
    total_checks++;
    if (phase !== exp) begin
      n_fail++;
      $display("unexpected phase at %0t: got %h expected %h", $time, phase, exp);
    end
  endtask

  // pattern of a format at a position, bit 0 = A
  function automatic logic [3:0] exp_pat(input int f, input int p);
    logic [31:0] t;
    case (f)
      0: t = 32'h00008421;
      1: t = 32'h0000C639;
      default: t = 32'h98C46231;
    endcase
    return t[p*4 +: 4];
  endfunction

  // wait for hready high at a rising edge, bounded
  task automatic wait_rdy();
    int i;
    i = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      i++;
      if (i > 20) begin
        n_fail++;
        finish_test();
      end
      @(posedge clk);
    end
  endtask

  // one single word transfer; read data taken at the closing edge
  task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rdo);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {28'h0, a};
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rdo = hrdata;
    chk_w({31'h0, hresp}, 32'h0);
  endtask

  // reset held 12 cycles; phases show A only meanwhile
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    chk_ph(4'h1);
    rstn <= 1'b1;
    pos = 0;
    repeat (8) @(posedge clk);
  endtask

  // one step pulse in a direction, checked after rise and after fall
  task automatic step_chk(input int dd, input bit dark);
    int m;
    m = (fmt == 2) ? 8 : 4;
    pos = pos % m;
    ctl_u.set_mode(fmt == 2, fmt == 0, dd[0]);
    ctl_u.drive(1'b1, 7 + {$random(seed)} % 3);
    chk_ph(dark ? 4'h0 : exp_pat(fmt, pos));
    ctl_u.drive(1'b0, 7 + {$random(seed)} % 3);
    pos = (pos + (dd != 0 ? m - 1 : 1)) % m;
    chk_ph(dark ? 4'h0 : exp_pat(fmt, pos));
  endtask

  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    blank = 1'b0;
    hot = 1'b0;
    cool = 1'b0;
    n_fail = 0;
    total_checks = 0;
    seed = 20135;
    fmt = 1;
    do_reset();
    chk_ph(4'h9);
    end_test("power-on");
    // wave, two-phase and half-step formats, one reverse step across the wrap, then forward, then random direction
    for (fmt = 0; fmt < 3; fmt++) begin
      ctl_u.set_mode(fmt == 2, fmt == 0, 1'b0);
      do_reset();
      chk_ph(exp_pat(fmt, 0));
      for (n = 0; n < 20; n++) begin
        step_chk(n == 0 ? 1 : n < 10 ? 0 : {$random(seed)} % 2, 1'b0);
      end
      end_test("format walk");
    end
    // inhibited stepping keeps the pattern and flags the refused step
    ahb(1'b0, REG_IRQ_STAT, 32'h0, rd);
    ctl_u.set_mode(1'b1, 1'b1, 1'b0);
    held = phase;
    ctl_u.drive(1'b1, 8);
    ctl_u.drive(1'b0, 8);
    chk_ph(held);
    ahb(1'b0, REG_IRQ_STAT, 32'h0, rd);
    chk_w(rd, 32'h2);
    end_test("inhibit");
    // half-step to position five, two-phase then keeps pos[1:0]; status write dropped
    fmt = 2;
    ctl_u.set_mode(1'b1, 1'b0, 1'b0);
    do_reset();
    for (n = 0; n < 5; n++) begin
      step_chk(0, 1'b0);
    end
    fmt = 1;
    step_chk(1, 1'b0);
    ahb(1'b1, REG_STATUS, 32'hFFFFFFFF, rd);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk_w(rd & 32'h0000F1FF, {16'h0, exp_pat(1, pos), 3'h0, 2'b01, 4'h2, pos[2:0]});
    // step interrupt raised when unmasked, cleared by reading, silent when masked
    ahb(1'b0, REG_IRQ_STAT, 32'h0, rd);
    ahb(1'b1, REG_IRQ_MASK, 32'h1, rd);
    ahb(1'b0, REG_IRQ_MASK, 32'h0, rd);
    chk_w(rd, 32'h1);
    step_chk(0, 1'b0);
    chk_w({31'h0, irq}, 32'h1);
    ahb(1'b0, REG_IRQ_STAT, 32'h0, rd);
    chk_w(rd, 32'h1);
    repeat (2) @(posedge clk);
    chk_w({31'h0, irq}, 32'h0);
    ahb(1'b1, REG_IRQ_MASK, 32'h0, rd);
    step_chk(0, 1'b0);
    chk_w({31'h0, irq}, 32'h0);
    end_test("registers");
    // blanking by pin and by register leaves the position alone
    blank <= 1'b1;
    repeat (8) @(posedge clk);
    chk_ph(4'h0);
    step_chk(0, 1'b1);
    blank <= 1'b0;
    repeat (8) @(posedge clk);
    chk_ph(exp_pat(1, pos));
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    repeat (3) @(posedge clk);
    chk_ph(4'h0);
    ahb(1'b1, REG_CTRL, 32'h0, rd);
    repeat (3) @(posedge clk);
    chk_ph(exp_pat(1, pos));
    end_test("blanking");
    // thermal trip holds the outputs off until the cool indication
    ahb(1'b0, REG_IRQ_STAT, 32'h0, rd);
    hot <= 1'b1;
    repeat (8) @(posedge clk);
    chk_ph(4'h0);
    hot <= 1'b0;
    repeat (8) @(posedge clk);
    chk_ph(4'h0);
    cool <= 1'b1;
    repeat (8) @(posedge clk);
    chk_ph(exp_pat(1, pos));
    cool <= 1'b0;
    ahb(1'b0, REG_IRQ_STAT, 32'h0, rd);
    chk_w(rd, 32'hC);
    end_test("thermal");
    finish_test();
  end
endmodule

`default_nettype wire
